// *** design/pifb_irq_flags.sv ***
// Purpose: Peripheral event flag bank reached over APB.
// Assumes: Event strobes and status levels come from logic on ref_clk.
// Notes:   Zero-wait APB slave; only byte lane 0 carries register data.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pifb_defines.svh"

module pifb_irq_flags #(
    parameter int ADDR_W      = 12,
    parameter int PWM_CH      = 4,
    parameter int LOGIC_CELLS = 4
) (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ADDR_W-1:0]           paddr,
    input  wire logic [`PIFB_DATA_W-1:0]     pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [`PIFB_DATA_W-1:0]     prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Capture/compare unit and timers
    input  wire pifb_pkg::pifb_ccp_mode_type ccpMode,
    input  wire logic                        ccpCaptureEv,
    input  wire logic                        ccpCompareEv,
    input  wire logic                        ccpPwmOut,
    input  wire logic                        tmr6Ev,
    input  wire logic                        tmr4Ev,
    input  wire logic                        tmr2Ev,
    input  wire logic                        tmr3GateActive,
    input  wire logic                        tmr3Ev,
    // PWM channels, index 0 is channel 1
    input  wire logic [PWM_CH-1:0]           pwmParamEv,
    input  wire logic [PWM_CH-1:0]           pwmPeriodEv,
    // Serial port 1, logic cells, waveform generator, oscillator
    input  wire logic                        serial1RxNotEmpty,
    input  wire logic                        serial1TxEmpty,
    input  wire logic [LOGIC_CELLS-1:0]      logicCellEv,
    input  wire logic                        waveGen1Ev,
    input  wire logic                        numOsc1Ev,
    // Flags towards the core
    output logic      [`PIFB_CAPTMR_W-1:0]   capTimerFlags,
    output logic      [`PIFB_REG_W-1:0]      pwmFlags,
    output logic      [`PIFB_REG_W-1:0]      serialLogicFlags
);
    import pifb_pkg::*;

    localparam logic [ADDR_W-1:0] ADDR_CAPTMR = ADDR_W'({`PIFB_IDX_CAPTMR, `PIFB_IDX_LSB});
    localparam logic [ADDR_W-1:0] ADDR_PWM    = ADDR_W'({`PIFB_IDX_PWM, `PIFB_IDX_LSB});
    localparam logic [ADDR_W-1:0] ADDR_SERIAL = ADDR_W'({`PIFB_IDX_SERIAL, `PIFB_IDX_LSB});

    pifb_top_state_type              st_reg;
    pifb_top_state_type              st_next;
    logic                            ccpEvent;
    logic                            gateFall;
    logic [`PIFB_CAPTMR_W-1:0]       capTmrSet;
    logic [`PIFB_REG_W-1:0]          pwmSet;
    logic [`PIFB_LOGIC_W-1:0]        logicSet;
    logic [`PIFB_LOGIC_W-1:0]        logicFlagsQ;
    logic                            setupPhase;
    logic                            accessDone;
    logic                            wrLane;
    logic                            wrCapTmr;
    logic                            wrPwm;
    logic                            wrSerial;
    logic                            rdHit;
    logic [`PIFB_DATA_W-1:0]         rdMux;

    // Capture/compare event selection by unit mode.
    pifb_ccp_event u_ccp (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .ccpMode   (ccpMode),
        .captureEv (ccpCaptureEv),
        .compareEv (ccpCompareEv),
        .pwmOut    (ccpPwmOut),
        .ccpEvent  (ccpEvent)
    );

    // The gate flag wants the moment the gate drops, not its level.
    assign gateFall = st_reg.gatePrev && !tmr3GateActive;

    assign capTmrSet[`PIFB_BIT_CCP1]  = ccpEvent;
    assign capTmrSet[`PIFB_BIT_TMR6]  = tmr6Ev;
    assign capTmrSet[`PIFB_BIT_TMR4]  = tmr4Ev;
    assign capTmrSet[`PIFB_BIT_TMR2]  = tmr2Ev;
    assign capTmrSet[`PIFB_BIT_TMR3G] = gateFall;
    assign capTmrSet[`PIFB_BIT_TMR3]  = tmr3Ev;

    for (genvar ch = 0; ch < PWM_CH; ch++) begin : g_pwm
        assign pwmSet[ch*`PIFB_PWM_STRIDE+`PIFB_PWM_PAR_OFS] = pwmParamEv[ch];
        assign pwmSet[ch*`PIFB_PWM_STRIDE+`PIFB_PWM_PER_OFS] = pwmPeriodEv[ch];
    end

    assign logicSet[`PIFB_BIT_CLC_LO +: LOGIC_CELLS] = logicCellEv;
    assign logicSet[`PIFB_BIT_CWG1] = waveGen1Ev;
    assign logicSet[`PIFB_BIT_NCO1] = numOsc1Ev;

    // APB decode; writes land at the edge that completes the access phase.
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && st_reg.pready;
    assign wrLane     = accessDone && pwrite && pstrb[0];
    assign wrCapTmr   = wrLane && (paddr == ADDR_CAPTMR);
    assign wrPwm      = wrLane && (paddr == ADDR_PWM);
    assign wrSerial   = wrLane && (paddr == ADDR_SERIAL);

    pifb_flag_bank #(.W(`PIFB_CAPTMR_W)) u_captmr (
        .ref_clk (ref_clk),
        .rst     (rst),
        .setEv   (capTmrSet),
        .wrEn    (wrCapTmr),
        .wrData  (pwdata[`PIFB_CAPTMR_W-1:0]),
        .flags   (capTimerFlags)
    );

    pifb_flag_bank #(.W(`PIFB_REG_W)) u_pwm (
        .ref_clk (ref_clk),
        .rst     (rst),
        .setEv   (pwmSet),
        .wrEn    (wrPwm),
        .wrData  (pwdata[`PIFB_REG_W-1:0]),
        .flags   (pwmFlags)
    );

    // Bits 7 and 6 are not in this bank, so a write cannot touch them.
    pifb_flag_bank #(.W(`PIFB_LOGIC_W)) u_logic (
        .ref_clk (ref_clk),
        .rst     (rst),
        .setEv   (logicSet),
        .wrEn    (wrSerial),
        .wrData  (pwdata[`PIFB_LOGIC_W-1:0]),
        .flags   (logicFlagsQ)
    );

    assign serialLogicFlags = {st_reg.rxFlag, st_reg.txFlag, logicFlagsQ};

    always_comb begin
        rdMux = `PIFB_RDATA_IDLE;
        rdHit = 1'b1;
        case (paddr)
            ADDR_CAPTMR: rdMux[`PIFB_CAPTMR_W-1:0] = capTimerFlags;
            ADDR_PWM:    rdMux[`PIFB_REG_W-1:0]    = pwmFlags;
            ADDR_SERIAL: rdMux[`PIFB_REG_W-1:0]    = serialLogicFlags;
            default:     rdHit = 1'b0;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        // Buffer levels are mirrored; the serial port clears them itself.
        st_next.rxFlag   = serial1RxNotEmpty;
        st_next.txFlag   = serial1TxEmpty;
        st_next.gatePrev = tmr3GateActive;
        st_next.pready   = setupPhase;
        st_next.pslverr  = setupPhase && !rdHit;
        if (setupPhase) begin
            st_next.prdata = rdMux;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg <= PIFB_TOP_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata  = st_reg.prdata;
    assign pready  = st_reg.pready;
    assign pslverr = st_reg.pslverr;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_ccp_capture: assert property (
        (ccpMode == PIFB_CCP_CAPTURE && ccpCaptureEv) |=> capTimerFlags[`PIFB_BIT_CCP1]
    ) else $error("Capture event did not set the unit flag.");

    a_ccp_trail: assert property (
        (ccpMode == PIFB_CCP_PWM && $past(ccpMode) == PIFB_CCP_PWM && $fell(ccpPwmOut))
        |=> capTimerFlags[`PIFB_BIT_CCP1]
    ) else $error("PWM trailing edge did not set the unit flag.");

    a_ccp_hold: assert property (
        (capTimerFlags[`PIFB_BIT_CCP1] && !wrCapTmr) |=> capTimerFlags[`PIFB_BIT_CCP1]
    ) else $error("Unit flag dropped without a software write.");

    a_timer_set: assert property (
        (tmr6Ev || tmr4Ev || tmr2Ev)
        |=> ((capTimerFlags[`PIFB_BIT_TMR6:`PIFB_BIT_TMR2] & {$past(tmr6Ev), $past(tmr4Ev), $past(tmr2Ev)})
             == {$past(tmr6Ev), $past(tmr4Ev), $past(tmr2Ev)})
    ) else $error("Timer event did not set its flag.");

    a_timer2_hold: assert property (
        (capTimerFlags[`PIFB_BIT_TMR2] && !wrCapTmr) |=> capTimerFlags[`PIFB_BIT_TMR2]
    ) else $error("Timer 2 flag dropped without a write.");

    a_gate_fall: assert property (
        (!$past(rst) && $fell(tmr3GateActive)) |=> capTimerFlags[`PIFB_BIT_TMR3G]
    ) else $error("Gate falling edge did not set the gate flag.");

    a_gate_quiet: assert property (
        (!capTimerFlags[`PIFB_BIT_TMR3G] && !gateFall && !(wrCapTmr && pwdata[`PIFB_BIT_TMR3G]))
        |=> !capTimerFlags[`PIFB_BIT_TMR3G]
    ) else $error("Gate flag rose with no gate event.");

    a_tmr3_set: assert property (
        tmr3Ev |=> capTimerFlags[`PIFB_BIT_TMR3] [*1]
    ) else $error("Timer 3 event did not set its flag.");

    a_pwm_reset: assert property (
        $past(rst) |-> (pwmFlags == `PIFB_FLAG_RESET && serialLogicFlags == `PIFB_FLAG_RESET)
    ) else $error("Flag registers not zero after reset.");

    a_pwm_read: assert property (
        (setupPhase && !pwrite && paddr == ADDR_PWM)
        |=> (pready && !pslverr && prdata[`PIFB_REG_W-1:0] == $past(pwmFlags))
    ) else $error("PWM flag read returned wrong data.");

    a_pwm_param: assert property (
        pwmParamEv[PWM_CH-1] |=> pwmFlags[(PWM_CH-1)*`PIFB_PWM_STRIDE+`PIFB_PWM_PAR_OFS]
    ) else $error("Channel parameter event not latched.");

    a_pwm_period: assert property (
        pwmPeriodEv[0] |=> pwmFlags[`PIFB_PWM_PER_OFS]
    ) else $error("Channel period event not latched.");

    a_serial_decode: assert property (
        (setupPhase && paddr == ADDR_SERIAL) |=> (pready && !pslverr) ##1 !pready
    ) else $error("Serial/logic register not answered in one access cycle.");

    a_rx_level: assert property (
        !$past(rst) |-> serialLogicFlags[`PIFB_BIT_RX1] == $past(serial1RxNotEmpty)
    ) else $error("Receive flag does not follow the buffer level.");

    a_tx_level: assert property (
        !$past(rst) |-> serialLogicFlags[`PIFB_BIT_TX1] == $past(serial1TxEmpty)
    ) else $error("Transmit flag does not follow the buffer level.");

    a_cell_set: assert property (
        logicCellEv[LOGIC_CELLS-1] |=> serialLogicFlags[`PIFB_BIT_CLC_LO+LOGIC_CELLS-1]
    ) else $error("Logic cell event not latched.");

    a_wavegen_set: assert property (
        waveGen1Ev |=> serialLogicFlags[`PIFB_BIT_CWG1]
    ) else $error("Waveform generator event not latched.");

    a_osc_set: assert property (
        numOsc1Ev |=> serialLogicFlags[`PIFB_BIT_NCO1]
    ) else $error("Oscillator event not latched.");

    a_set_wins: assert property (
        (tmr2Ev && wrCapTmr && !pwdata[`PIFB_BIT_TMR2]) |=> capTimerFlags[`PIFB_BIT_TMR2]
    ) else $error("Software clear swallowed a timer 2 event.");

    // An unmapped access must still complete, or the core would stall on it.
    a_unmapped_err: assert property (
        (setupPhase && !rdHit) |=> (pready && pslverr && prdata == `PIFB_RDATA_IDLE)
    ) else $error("Unmapped access not refused.");

    a_ccp_compare: assert property (
        (ccpMode == PIFB_CCP_COMPARE && ccpCompareEv) |=> capTimerFlags[`PIFB_BIT_CCP1]
    ) else $error("Compare match did not set the unit flag.");

    a_tmr3_hold: assert property (
        (capTimerFlags[`PIFB_BIT_TMR3] && !wrCapTmr) |=> capTimerFlags[`PIFB_BIT_TMR3]
    ) else $error("Timer 3 flag dropped without a write.");

    a_pwm_hold: assert property (
        (pwmFlags[`PIFB_PWM_PER_OFS] && !wrPwm) |=> pwmFlags[`PIFB_PWM_PER_OFS]
    ) else $error("Channel period flag dropped without a write.");

    a_cell_hold: assert property (
        (serialLogicFlags[`PIFB_BIT_CLC_LO] && !wrSerial) |=> serialLogicFlags[`PIFB_BIT_CLC_LO]
    ) else $error("Logic cell flag dropped without a write.");

endmodule

`default_nettype wire

// *** design/pifb_defines.svh ***
// Purpose: Named constants of the peripheral flag bank.
// Assumes: Included by the package and by the pifb_irq_flags and pifb_flag_bank modules.
// Notes:   Register offsets are word indexes; byte address is index times four.
`ifndef PIFB_DEFINES_SVH
`define PIFB_DEFINES_SVH

`define PIFB_IDX_CAPTMR   8'h8E
`define PIFB_IDX_PWM      8'h8F
`define PIFB_IDX_SERIAL   8'h90
`define PIFB_IDX_LSB      2'h0

`define PIFB_FLAG_RESET   8'h00
`define PIFB_RDATA_IDLE   32'h0000_0000
`define PIFB_DATA_W       32
`define PIFB_REG_W        8
`define PIFB_CAPTMR_W     6
`define PIFB_LOGIC_W      6

`define PIFB_BIT_CCP1     5
`define PIFB_BIT_TMR6     4
`define PIFB_BIT_TMR4     3
`define PIFB_BIT_TMR2     2
`define PIFB_BIT_TMR3G    1
`define PIFB_BIT_TMR3     0

`define PIFB_PWM_STRIDE   2
`define PIFB_PWM_PAR_OFS  1
`define PIFB_PWM_PER_OFS  0

`define PIFB_BIT_RX1      7
`define PIFB_BIT_TX1      6
`define PIFB_BIT_CLC_LO   2
`define PIFB_BIT_CWG1     1
`define PIFB_BIT_NCO1     0

`endif

// *** design/pifb_pkg.sv ***
// Purpose: Types shared by the peripheral flag bank modules.
// Assumes: Constants come from pifb_defines.svh.
// Notes:   Reset values of the state records are all zero.
`include "pifb_defines.svh"

package pifb_pkg;

    typedef enum logic [1:0] {
        PIFB_CCP_CAPTURE = 2'b00,
        PIFB_CCP_COMPARE = 2'b01,
        PIFB_CCP_PWM     = 2'b10,
        PIFB_CCP_OFF     = 2'b11
    } pifb_ccp_mode_type;

    typedef struct packed {
        logic [`PIFB_DATA_W-1:0] prdata;
        logic                    pready;
        logic                    pslverr;
        logic                    gatePrev;
        logic                    rxFlag;
        logic                    txFlag;
    } pifb_top_state_type;

    typedef struct packed {
        logic pwmPrev;
    } pifb_ccp_state_type;

    localparam pifb_top_state_type PIFB_TOP_RESET = '{default: '0};
    localparam pifb_ccp_state_type PIFB_CCP_RESET = '{default: '0};

endpackage

// *** design/pifb_ccp_event.sv ***
// Purpose: Picks the capture/compare unit event that sets its flag.
// Assumes: All inputs come from logic on ref_clk.
// Notes:   The PWM trailing edge is found in the first cycle the output is low, not one cycle later.
`timescale 1ns/1ps
`default_nettype none

module pifb_ccp_event (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    // Unit side
    input  wire pifb_pkg::pifb_ccp_mode_type ccpMode,
    input  wire logic                        captureEv,
    input  wire logic                        compareEv,
    input  wire logic                        pwmOut,
    // Flag side
    output logic                             ccpEvent
);
    import pifb_pkg::*;

    pifb_ccp_state_type st_reg;
    pifb_ccp_state_type st_next;
    logic               trailEdge;

    assign trailEdge = st_reg.pwmPrev && !pwmOut;

    always_comb begin
        st_next = st_reg;
        st_next.pwmPrev = pwmOut;
        unique case (ccpMode)
            PIFB_CCP_CAPTURE: ccpEvent = captureEv;
            PIFB_CCP_COMPARE: ccpEvent = compareEv;
            PIFB_CCP_PWM:     ccpEvent = trailEdge;
            PIFB_CCP_OFF:     ccpEvent = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg <= PIFB_CCP_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

`default_nettype wire

// *** design/pifb_flag_bank.sv ***
// Purpose: A row of sticky flags that hardware sets and software writes.
// Assumes: Set strobes and the write strobe are on ref_clk.
// Notes:   A set in the cycle of a write always wins.
`timescale 1ns/1ps
`default_nettype none
`include "pifb_defines.svh"

module pifb_flag_bank #(
    parameter int W = `PIFB_REG_W
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Hardware events
    input  wire logic [W-1:0] setEv,
    // Software write
    input  wire logic         wrEn,
    input  wire logic [W-1:0] wrData,
    // Flags
    output logic      [W-1:0] flags
);
    import pifb_pkg::*;

    typedef struct packed {
        logic [W-1:0] flags;
    } pifb_bank_state_type;

    pifb_bank_state_type st_reg;
    pifb_bank_state_type st_next;
    logic [W-1:0]        flagNext;

    // The set term is ORed last so that a clear never swallows an event.
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign flagNext[i] = setEv[i] | (wrEn ? wrData[i] : st_reg.flags[i]);
    end

    always_comb begin
        st_next = st_reg;
        st_next.flags = flagNext;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg.flags <= W'(`PIFB_FLAG_RESET);
        end else begin
            st_reg <= st_next;
        end
    end

    assign flags = st_reg.flags;

endmodule

`default_nettype wire

// *** tb/pifb_serial_model.sv ***
// Purpose: Behavioural serial port 1 buffers that feed the receive and transmit status levels.
// Assumes: Strobes come from the bench on ref_clk, one cycle each.
// Notes:   The receive side holds up to three bytes, so a single read does not always empty it.
`timescale 1ns/1ps
`default_nettype none

module pifb_serial_model (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Core side strobes
    input  wire logic rxPush,
    input  wire logic rxPop,
    input  wire logic txLoad,
    input  wire logic txShift,
    // Status towards the flag bank
    output logic      rxNotEmpty,
    output logic      txEmpty
);
    typedef struct packed {
        logic [1:0] rxCount;
        logic       txFull;
    } pifb_serial_state_type;

    pifb_serial_state_type state_reg;
    pifb_serial_state_type state_next;

    always_comb begin
        state_next = state_reg;
        if (rxPush && !rxPop && state_reg.rxCount != 2'h3) begin
            state_next.rxCount = state_reg.rxCount + 2'h1;
        end else if (rxPop && !rxPush && state_reg.rxCount != 2'h0) begin
            state_next.rxCount = state_reg.rxCount - 2'h1;
        end
        if (txLoad) begin
            state_next.txFull = 1'b1;
        end else if (txShift) begin
            state_next.txFull = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // The transmit level says only that the holding buffer is free, not that the line went quiet.
    assign rxNotEmpty = (state_reg.rxCount != 2'h0);
    assign txEmpty    = !state_reg.txFull;
endmodule

`default_nettype wire

// *** tb/peripheral_irq_flag_bank_bench.sv ***
// Purpose: Self-checking bench for the peripheral event flag bank.
// Assumes: Zero-wait APB slave; flags appear one cycle after an event is sampled.
// Notes:   Events are packed in one vector; MAP gives the bit of each of the first 18 in the joined flag word.
`timescale 1ns/1ps
`default_nettype none

module peripheral_irq_flag_bank_bench;
    import pifb_pkg::*;

    localparam logic [11:0] A_CAP = 12'h238;
    localparam logic [11:0] A_PWM = 12'h23C;
    localparam logic [11:0] A_SER = 12'h240;
    localparam logic [11:0] A_BAD = 12'h244;
    localparam int MAP [18] = '{9, 11, 13, 15, 8, 10, 12, 14, 2, 3, 4, 5, 1, 0, 16, 18, 19, 20};

    logic              ref_clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
    logic              ccpPwmOut, tmr3GateActive, rxNotEmpty, txEmpty;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rdat;
    logic [3:0]        pstrb, ser;
    logic [19:0]       evs;
    logic [5:0]        capTimerFlags;
    logic [7:0]        pwmFlags, serialLogicFlags;
    logic [21:0]       allFlags, expF;
    pifb_ccp_mode_type ccpMode;
    int                fails, checkCount;

    assign allFlags = {capTimerFlags, pwmFlags, serialLogicFlags};

    pifb_irq_flags dut (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ccpMode(ccpMode), .ccpCaptureEv(evs[18]), .ccpCompareEv(evs[19]),
        .ccpPwmOut(ccpPwmOut), .tmr6Ev(evs[17]), .tmr4Ev(evs[16]), .tmr2Ev(evs[15]),
        .tmr3GateActive(tmr3GateActive), .tmr3Ev(evs[14]), .pwmParamEv(evs[3:0]),
        .pwmPeriodEv(evs[7:4]), .serial1RxNotEmpty(rxNotEmpty), .serial1TxEmpty(txEmpty),
        .logicCellEv(evs[11:8]), .waveGen1Ev(evs[12]), .numOsc1Ev(evs[13]),
        .capTimerFlags(capTimerFlags), .pwmFlags(pwmFlags), .serialLogicFlags(serialLogicFlags)
    );

    pifb_serial_model partner (
        .ref_clk(ref_clk), .rst(rst), .rxPush(ser[0]), .rxPop(ser[1]), .txLoad(ser[2]),
        .txShift(ser[3]), .rxNotEmpty(rxNotEmpty), .txEmpty(txEmpty)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checkCount++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // A hit raises the timer 2 event during the access phase, to collide with the write.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic hit);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        evs[15] <= hit;
        // Only the watchdog ends a wait that never sees pready.
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        evs[15] <= 1'b0;
    endtask

    task automatic pulse(input int i);
        @(posedge ref_clk);
        evs[i] <= 1'b1;
        @(posedge ref_clk);
        evs[i] <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic strobe(input int k);
        @(posedge ref_clk);
        ser[k] <= 1'b1;
        @(posedge ref_clk);
        ser[k] <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_edges(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    task automatic t_events;
        expF = 22'h000040;
        for (int i = 0; i < 18; i++) begin
            pulse(i);
            expF[MAP[i]] = 1'b1;
            chk(32'(allFlags), 32'(expF), "event flag set");
        end
        wait_edges(5);
        chk(32'(allFlags), 32'(expF), "flags hold");
        apb(1'b0, A_CAP, 32'h0, 4'hF, 1'b0);
        chk(rdat, 32'h0000_001D, "timer register read");
        apb(1'b0, A_PWM, 32'h0, 4'hF, 1'b0);
        chk(rdat, 32'h0000_00FF, "pwm register read");
        apb(1'b1, A_SER, 32'h0000_00BF, 4'hF, 1'b0);
        apb(1'b0, A_SER, 32'h0, 4'hF, 1'b0);
        chk(rdat, 32'h0000_007F, "status bits ignore writes");
        apb(1'b1, A_CAP, 32'h0, 4'hF, 1'b0);
        apb(1'b1, A_PWM, 32'h0, 4'hF, 1'b0);
        apb(1'b1, A_SER, 32'h0, 4'hF, 1'b0);
        #1;
        chk(32'(allFlags), 32'h0000_0040, "software clear");
        $display("events test done");
    endtask

    task automatic t_ccp;
        @(posedge ref_clk);
        ccpMode <= PIFB_CCP_OFF;
        pulse(18);
        pulse(19);
        chk(32'(allFlags[21]), 32'h0, "unit off sets nothing");
        @(posedge ref_clk);
        ccpMode <= PIFB_CCP_CAPTURE;
        pulse(18);
        chk(32'(allFlags[21]), 32'h1, "capture sets flag");
        apb(1'b1, A_CAP, 32'h0, 4'hF, 1'b0);
        ccpMode <= PIFB_CCP_COMPARE;
        pulse(19);
        chk(32'(allFlags[21]), 32'h1, "compare sets flag");
        apb(1'b1, A_CAP, 32'h0, 4'hF, 1'b0);
        ccpMode   <= PIFB_CCP_PWM;
        ccpPwmOut <= 1'b1;
        tmr3GateActive <= 1'b1;
        wait_edges(4);
        chk(32'(capTimerFlags), 32'h0, "rising edges set nothing");
        @(posedge ref_clk);
        ccpPwmOut <= 1'b0;
        tmr3GateActive <= 1'b0;
        wait_edges(4);
        chk(32'(capTimerFlags), 32'h0000_0022, "falling edges set flags");
        apb(1'b1, A_CAP, 32'h0, 4'hF, 1'b0);
        #1;
        chk(32'(capTimerFlags), 32'h0, "unit flags cleared");
        $display("capture unit test done");
    endtask

    task automatic t_bus;
        pulse(15);
        apb(1'b1, A_CAP, 32'h0, 4'hF, 1'b1);
        #1;
        chk(32'(capTimerFlags), 32'h0000_0004, "set beats clear");
        apb(1'b1, A_CAP, 32'h0, 4'hF, 1'b0);
        apb(1'b1, A_PWM, 32'h0000_00FF, 4'hE, 1'b0);
        apb(1'b0, A_PWM, 32'h0, 4'hF, 1'b0);
        chk(rdat, 32'h0, "write without lane ignored");
        apb(1'b1, A_BAD, 32'h0000_00FF, 4'hF, 1'b0);
        chk(32'(rerr), 32'h1, "unmapped write refused");
        apb(1'b0, A_BAD, 32'h0, 4'hF, 1'b0);
        chk({rdat[30:0], rerr}, 32'h1, "unmapped read refused");
        apb(1'b1, A_PWM, 32'hFFFF_FF5A, 4'hF, 1'b0);
        apb(1'b0, A_PWM, 32'h0, 4'hF, 1'b0);
        chk({rdat[30:0], rerr}, 32'h0000_00B4, "pwm write sets and clears");
        apb(1'b1, A_PWM, 32'h0, 4'hF, 1'b0);
        $display("bus test done");
    endtask

    task automatic t_serial;
        strobe(0);
        strobe(0);
        chk(32'(serialLogicFlags), 32'h0000_00C0, "receive data present");
        apb(1'b1, A_SER, 32'h0, 4'hF, 1'b0);
        #1;
        chk(32'(serialLogicFlags[7]), 32'h1, "receive flag ignores write");
        strobe(1);
        chk(32'(serialLogicFlags[7]), 32'h1, "one byte still held");
        strobe(1);
        chk(32'(serialLogicFlags[7]), 32'h0, "receive buffer empty");
        strobe(2);
        chk(32'(serialLogicFlags[6]), 32'h0, "transmit buffer full");
        apb(1'b1, A_SER, 32'h0000_00FF, 4'hF, 1'b0);
        #1;
        chk(32'(serialLogicFlags), 32'h0000_003F, "status unchanged by write");
        strobe(3);
        chk(32'(serialLogicFlags[6]), 32'h1, "transmit buffer free");
        apb(1'b1, A_SER, 32'h0, 4'hF, 1'b0);
        $display("serial test done");
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #300us;
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        evs = 20'h0;
        ser = 4'h0;
        ccpMode = PIFB_CCP_OFF;
        ccpPwmOut = 1'b0;
        tmr3GateActive = 1'b0;
        fails = 0;
        checkCount = 0;
        repeat (3) @(posedge ref_clk);
        chk(32'(allFlags), 32'h0, "flags clear in reset");
        rst <= 1'b0;
        wait_edges(2);
        t_events();
        t_ccp();
        t_bus();
        t_serial();
        wrap_up();
    end
endmodule

`default_nettype wire
